// ---- hw/gain_switch_pkg.sv ----
// constants, register map and types for the gain-set switcher
package gain_switch_pkg;

    // ****************************************
    // sizes
    // ****************************************
    localparam int DATA_W    = 16;
    localparam int NUM_GAINS = 6;
    localparam int NUM_REGS  = 16;
    localparam int FRAC_W    = 8;

    // ****************************************
    // byte offsets
    // ****************************************
    localparam logic [7:0] OFF_SRC_SEL   = 8'h00;
    localparam logic [7:0] OFF_THRESHOLD = 8'h04;
    localparam logic [7:0] OFF_TIME_CONST = 8'h08;
    localparam logic [7:0] OFF_ALT_BASE  = 8'h0c;
    localparam logic [7:0] OFF_NORM_BASE = 8'h24;
    localparam logic [7:0] OFF_MODE_CTRL = 8'h3c;
    localparam logic [7:0] OFF_STATUS    = 8'h40;
    localparam logic [7:0] OFF_RELOAD    = 8'h44;

    // register array indices
    localparam logic [3:0] IDX_SRC_SEL   = 4'h0;
    localparam logic [3:0] IDX_THRESHOLD = 4'h1;
    localparam logic [3:0] IDX_TIME_CONST = 4'h2;
    localparam int         IDX_ALT_BASE  = 3;
    localparam int         IDX_NORM_BASE = 9;
    localparam logic [3:0] IDX_MODE_CTRL = 4'hf;

    // ****************************************
    // fields
    // ****************************************
    localparam int SRC_LSB   = 0;
    localparam int POL_LSB   = 4;
    localparam int AUTO_LSB  = 0;
    localparam int VIB_LSB   = 4;
    localparam int SPEED_BIT = 8;

    typedef enum logic [3:0] {
        SRC_OFF   = 4'h0,
        SRC_CMD   = 4'h1,
        SRC_FREQ  = 4'h2,
        SRC_DROOP = 4'h3,
        SRC_SPEED = 4'h4
    } switch_src_t;

    localparam logic [3:0] AUTO_MODE_MANUAL = 4'h3;
    localparam logic [3:0] VIB_MODE_AUTO    = 4'h1;
    localparam logic [3:0] VIB_MODE_MANUAL  = 4'h2;

    // gain order: inertia, position, speed, integral, vibration, resonance
    localparam int G_INERTIA = 0;
    localparam int G_POS     = 1;
    localparam int G_SPEED   = 2;
    localparam int G_INTEG   = 3;
    localparam int G_VIB     = 4;
    localparam int G_RES     = 5;

    // ****************************************
    // reset values and limits (tenth units for ratio, ms and Hz)
    // ****************************************
    localparam logic [15:0] REG_RST [NUM_REGS] = '{
        16'h0000, 16'h000a, 16'h0001,
        16'h0046, 16'h0025, 16'h0337, 16'h0151, 16'h03e8, 16'h03e8,
        16'h0046, 16'h0025, 16'h0337, 16'h0151, 16'h03e8, 16'h03e8,
        16'h0000};
    localparam logic [15:0] REG_MIN [NUM_REGS] = '{
        16'h0000, 16'h0000, 16'h0000,
        16'h0000, 16'h0001, 16'h0014, 16'h0001, 16'h0001, 16'h0001,
        16'h0000, 16'h0001, 16'h0014, 16'h0001, 16'h0001, 16'h0001,
        16'h0000};
    localparam logic [15:0] REG_MAX [NUM_REGS] = '{
        16'h0014, 16'h270f, 16'h0064,
        16'h0bb8, 16'h07d0, 16'hc350, 16'hc350, 16'h03e8, 16'h03e8,
        16'h0bb8, 16'h07d0, 16'hc350, 16'hc350, 16'h03e8, 16'h03e8,
        16'h01ff};

    // ****************************************
    // timing
    // ****************************************
    localparam int CLK_PERIOD_NS = 50;
    localparam int NS_PER_MS     = 1000000;
    localparam int LAG_SHIFT     = 3;
    localparam int STEP_CYCLES   = (NS_PER_MS / CLK_PERIOD_NS) >> LAG_SHIFT;
    localparam logic [11:0] STEP_LAST = 12'(STEP_CYCLES - 1);

endpackage : gain_switch_pkg

// ---- hw/gain_lag_if.sv ----
// carrier between the switcher and one gain lag stage
`timescale 1ns/1ns
interface gain_lag_if;
    import gain_switch_pkg::*;
    logic [DATA_W-1:0] target;
    logic              step;
    logic              bypass;
    logic [DATA_W-1:0] value;

    modport ctrl (output target, output step, output bypass, input value);
    modport lag  (input target, input step, input bypass, output value);
endinterface : gain_lag_if

// ---- hw/gain_lag.sv ----
// first-order lag stage that walks one gain toward its target
`timescale 1ns/1ns
module gain_lag
    import gain_switch_pkg::*;
#(
    parameter logic [DATA_W-1:0] RESET_VAL = 16'h0000
) (
    input wire logic   clk,
    input wire logic   rst_n,
    gain_lag_if.lag    bus
);

    logic [DATA_W+FRAC_W:0]   acc_reg;
    logic [DATA_W+FRAC_W:0]   acc_next;
    logic [DATA_W+FRAC_W:0]   goal;
    logic [DATA_W+FRAC_W+1:0] diff;
    logic [DATA_W+FRAC_W+1:0] delta;
    logic                     near;

    assign goal  = {1'b0, bus.target, {FRAC_W{1'b0}}};
    assign diff  = {1'b0, goal} - {1'b0, acc_reg};
    assign delta = $signed(diff) >>> LAG_SHIFT;
    // shift stalls on tiny errors, so snap the last few counts
    assign near  = ($signed(diff) < $signed((DATA_W+FRAC_W+2)'(1 << LAG_SHIFT)))
                && ($signed(diff) > -$signed((DATA_W+FRAC_W+2)'(1 << LAG_SHIFT)));

    assign acc_next = (bus.bypass || near) ? goal
                    : (bus.step ? (DATA_W+FRAC_W+1)'(acc_reg + delta) : acc_reg);

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            acc_reg <= {1'b0, RESET_VAL, {FRAC_W{1'b0}}};
        end else if (bus.bypass || bus.step) begin
            acc_reg <= acc_next;
        end
    end

    assign bus.value = acc_reg[DATA_W+FRAC_W-1:FRAC_W];

endmodule : gain_lag

// ---- hw/gain_switch.sv ----
// gain-set switcher: APB registers, switch condition and gain lag
// ****************************************
// Overview of operation
// - source field: 0 off, 1 instruction, 2 frequency, 3 droop, 4 speed
// - while condition holds, alternate gain set replaces the normal one
// - polarity 0: instruction on, or quantity at or above threshold
// - polarity 1: instruction off, or quantity at or below threshold
// - threshold 0 to 9999, reset 10, unit follows source
// - transition time constant 0 to 100 ms, reset 1 ms
// - alternate ratio and loop gains apply only with auto tuning mode 3
// - speed mode ignores alternate position gain and both frequencies
// - alternate vibration frequency applies only with tuning mode 1
// - alternate resonance frequency needs tuning mode 2 and source 1
// - alternate position gain 1 to 2000, reset 37
// - alternate speed gain 20 to 50000, reset 823
// - alternate integral 0.1 to 5000.0 ms, reset 33.7
// - alternate inertia ratio 0 to 300.0, reset 7.0
// - alternate frequencies 0.1 to 100.0 Hz, reset 100.0
// - source selection changes only after reset or controller reload
// ****************************************
//
// Design decisions made here: the placing of the registers and the APB register port.
`timescale 1ns/1ns
module gain_switch
    import gain_switch_pkg::*;
(
    input  wire logic              clk,
    input  wire logic              reset_n,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [7:0]        paddr,
    input  wire logic [31:0]       pwdata,
    output logic      [31:0]       prdata,
    output logic                   pready,
    output logic                   pslverr,
    input  wire logic              gain_change_cmd,
    input  wire logic [DATA_W-1:0] command_freq,
    input  wire logic [DATA_W-1:0] droop_pulses,
    input  wire logic [DATA_W-1:0] motor_speed,
    output logic      [DATA_W-1:0] inertia_ratio,
    output logic      [DATA_W-1:0] position_gain,
    output logic      [DATA_W-1:0] speed_gain,
    output logic      [DATA_W-1:0] integral_comp,
    output logic      [DATA_W-1:0] vibration_freq,
    output logic      [DATA_W-1:0] resonance_freq,
    output logic                   gain_switch_active
);

    // ****************************************
    // reset release
    // ****************************************
    logic rst_meta_reg;
    logic rst_sync_reg;

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            rst_meta_reg <= 1'b0;
            rst_sync_reg <= 1'b0;
        end else begin
            rst_meta_reg <= 1'b1;
            rst_sync_reg <= rst_meta_reg;
        end
    end

    // ****************************************
    // register bus decode
    // ****************************************
    logic [DATA_W-1:0] regs_reg [NUM_REGS];
    logic              setup_phase;
    logic              access_done;
    logic              wr_en;
    logic              in_array;
    logic              is_status;
    logic              is_reload;
    logic              mapped;
    logic [3:0]        wr_idx;
    logic [DATA_W-1:0] wr_val;
    logic [DATA_W-1:0] wr_clamped;
    logic              reload_pulse;

    assign setup_phase = psel && !penable;
    assign access_done = psel && penable && pready;
    assign in_array    = (paddr[1:0] == 2'b00) && (paddr < OFF_STATUS);
    assign is_status   = (paddr == OFF_STATUS);
    assign is_reload   = (paddr == OFF_RELOAD);
    assign mapped      = in_array || is_status || is_reload;
    assign wr_en       = access_done && pwrite && in_array;
    assign wr_idx      = paddr[5:2];
    assign wr_val      = pwdata[DATA_W-1:0];

    assign wr_clamped = (wr_val < REG_MIN[wr_idx]) ? REG_MIN[wr_idx]
                      : (wr_val > REG_MAX[wr_idx]) ? REG_MAX[wr_idx]
                      : wr_val;

    assign reload_pulse = access_done && pwrite && is_reload;

    // ****************************************
    // register storage
    // ****************************************
    // limits and reset values
    genvar r;
    generate
        for (r = 0; r < NUM_REGS; r++) begin : g_reg
            always_ff @(posedge clk or negedge rst_sync_reg) begin
                if (!rst_sync_reg) begin
                    regs_reg[r] <= REG_RST[r];
                end else if (wr_en && (wr_idx == 4'(r))) begin
                    regs_reg[r] <= wr_clamped;
                end
            end
        end
    endgenerate

    // ****************************************
    // mode fields
    // ****************************************
    logic [3:0] src_field;
    logic       polarity;
    logic [3:0] auto_mode;
    logic [3:0] vib_mode;
    logic       speed_mode;
    logic [6:0] time_const;

    assign src_field  = regs_reg[IDX_SRC_SEL][SRC_LSB +: 4];
    assign polarity   = regs_reg[IDX_SRC_SEL][POL_LSB];
    assign auto_mode  = regs_reg[IDX_MODE_CTRL][AUTO_LSB +: 4];
    assign vib_mode   = regs_reg[IDX_MODE_CTRL][VIB_LSB +: 4];
    assign speed_mode = regs_reg[IDX_MODE_CTRL][SPEED_BIT];
    assign time_const = regs_reg[IDX_TIME_CONST][6:0];

    // ****************************************
    // active source selection
    // ****************************************
    // a live change of source mid-motion would jerk the loop
    logic        load_pending_reg;
    switch_src_t src_active_reg;
    logic        pol_active_reg;

    always_ff @(posedge clk or negedge rst_sync_reg) begin
        if (!rst_sync_reg) begin
            load_pending_reg <= 1'b1;
        end else begin
            load_pending_reg <= 1'b0;
        end
    end

    // source taken at reset or reload
    always_ff @(posedge clk or negedge rst_sync_reg) begin
        if (!rst_sync_reg) begin
            src_active_reg <= SRC_OFF;
            pol_active_reg <= 1'b0;
        end else if (load_pending_reg || reload_pulse) begin
            src_active_reg <= switch_src_t'(src_field);
            pol_active_reg <= polarity;
        end
    end

    // ****************************************
    // switch condition
    // ****************************************
    logic [DATA_W-1:0] quantity;
    logic [DATA_W-1:0] threshold;
    logic              is_quantity;
    logic              at_or_above;
    logic              at_or_below;
    logic              cmd_hit;
    logic              qty_hit;
    logic              condition;

    assign threshold = regs_reg[IDX_THRESHOLD];

    assign quantity = (src_active_reg == SRC_FREQ)  ? command_freq
                    : (src_active_reg == SRC_DROOP) ? droop_pulses
                    : motor_speed;

    assign is_quantity = (src_active_reg == SRC_FREQ)
                      || (src_active_reg == SRC_DROOP)
                      || (src_active_reg == SRC_SPEED);

    assign at_or_above = (quantity >= threshold);
    assign at_or_below = (quantity <= threshold);

    assign cmd_hit = pol_active_reg ? !gain_change_cmd : gain_change_cmd;
    assign qty_hit = pol_active_reg ? at_or_below : at_or_above;

    assign condition = ((src_active_reg == SRC_CMD) && cmd_hit)
                    || (is_quantity && qty_hit);

    logic switched_reg;

    always_ff @(posedge clk or negedge rst_sync_reg) begin
        if (!rst_sync_reg) begin
            switched_reg <= 1'b0;
        end else begin
            switched_reg <= condition;
        end
    end

    assign gain_switch_active = switched_reg;

    // ****************************************
    // per-gain permission
    // ****************************************
    logic [NUM_GAINS-1:0] alt_allowed;
    logic                 manual_tuning;

    assign manual_tuning = (auto_mode == AUTO_MODE_MANUAL);

    assign alt_allowed[G_INERTIA] = manual_tuning;
    assign alt_allowed[G_POS]     = manual_tuning && !speed_mode;
    assign alt_allowed[G_SPEED]   = manual_tuning;
    assign alt_allowed[G_INTEG]   = manual_tuning;
    assign alt_allowed[G_VIB]     = (vib_mode == VIB_MODE_AUTO) && !speed_mode;
    assign alt_allowed[G_RES]     = (vib_mode == VIB_MODE_MANUAL) && !speed_mode
                                 && (src_active_reg == SRC_CMD);

    // ****************************************
    // lag step timer
    // ****************************************
    // one lag step every eighth of the time constant
    logic [11:0] sub_cnt_reg;
    logic [6:0]  ms_cnt_reg;
    logic        sub_wrap;
    logic        ms_wrap;
    logic        step_reg;

    assign sub_wrap = (sub_cnt_reg == STEP_LAST);
    assign ms_wrap  = sub_wrap && (ms_cnt_reg >= time_const - 7'h01);

    always_ff @(posedge clk or negedge rst_sync_reg) begin
        if (!rst_sync_reg) begin
            sub_cnt_reg <= 12'h000;
            ms_cnt_reg  <= 7'h00;
            step_reg    <= 1'b0;
        end else begin
            sub_cnt_reg <= sub_wrap ? 12'h000 : sub_cnt_reg + 12'h001;
            ms_cnt_reg  <= ms_wrap ? 7'h00 : (sub_wrap ? ms_cnt_reg + 7'h01 : ms_cnt_reg);
            step_reg    <= ms_wrap;
        end
    end

    // ****************************************
    // gain selection and lag stages
    // ****************************************
    gain_lag_if lag_bus [NUM_GAINS] ();

    logic [DATA_W-1:0] gain_val [NUM_GAINS];

    genvar g;
    generate
        for (g = 0; g < NUM_GAINS; g++) begin : g_gain
            assign lag_bus[g].target = (switched_reg && alt_allowed[g])
                                     ? regs_reg[IDX_ALT_BASE + g]
                                     : regs_reg[IDX_NORM_BASE + g];
            assign lag_bus[g].step   = step_reg;
            assign lag_bus[g].bypass = (time_const == 7'h00);
            assign gain_val[g]       = lag_bus[g].value;

            gain_lag #(
                .RESET_VAL (REG_RST[IDX_NORM_BASE + g])
            ) u_lag (
                .clk   (clk),
                .rst_n (rst_sync_reg),
                .bus   (lag_bus[g])
            );
        end
    endgenerate

    assign inertia_ratio  = gain_val[G_INERTIA];
    assign position_gain  = gain_val[G_POS];
    assign speed_gain     = gain_val[G_SPEED];
    assign integral_comp  = gain_val[G_INTEG];
    assign vibration_freq = gain_val[G_VIB];
    assign resonance_freq = gain_val[G_RES];

    // ****************************************
    // read path and bus answer
    // ****************************************
    logic [31:0] status_word;
    logic [31:0] rd_word;

    assign status_word = {25'h0000000, src_active_reg, pol_active_reg,
                          switched_reg, condition};

    assign rd_word = in_array  ? {16'h0000, regs_reg[wr_idx]}
                   : is_status ? status_word
                   : 32'h00000000;

    // zero wait states: ready is registered from setup, high in the access cycle
    always_ff @(posedge clk or negedge rst_sync_reg) begin
        if (!rst_sync_reg) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h00000000;
        end else begin
            pready  <= setup_phase;
            pslverr <= setup_phase && !mapped;
            prdata  <= (setup_phase && !pwrite) ? rd_word : 32'h00000000;
        end
    end

endmodule : gain_switch

// ---- bench/gain_switch_monitor.sv ----
// port-level checks for the gain-set switcher
`timescale 1ns/1ns
module gain_switch_monitor
    import gain_switch_pkg::*;
(
    input wire logic              clk,
    input wire logic              reset_n,
    input wire logic              psel,
    input wire logic              penable,
    input wire logic [31:0]       prdata,
    input wire logic              pready,
    input wire logic              pslverr,
    input wire logic [DATA_W-1:0] inertia_ratio,
    input wire logic [DATA_W-1:0] position_gain,
    input wire logic [DATA_W-1:0] speed_gain,
    input wire logic [DATA_W-1:0] integral_comp,
    input wire logic [DATA_W-1:0] vibration_freq
);
    default clocking @(posedge clk); endclocking
    default disable iff (!reset_n);

    // ****************************************
    // bus answer
    // ****************************************
    sequence setup_phase;
        psel && !penable;
    endsequence
    sequence single_answer;
        pready ##1 !pready;
    endsequence
    a_setup_gets_ready: assert property (setup_phase |=> single_answer)
        else $error("ready missing or longer than one cycle");
    a_idle_data_zero: assert property (!pready |-> prdata == 32'h0000_0000)
        else $error("read data outside access cycle");
    a_upper_half_zero: assert property (pready |-> prdata[31:16] == 16'h0000)
        else $error("upper read half not zero");
    a_error_with_ready: assert property (pslverr |-> pready && $past(psel))
        else $error("error without answer");

    // ****************************************
    // effective gains except resonance frequency stay inside their ranges
    // ****************************************
    a_pos_gain_range: assert property (position_gain >= 16'h0001 && position_gain <= 16'h07d0)
        else $error("position gain out of range");
    a_speed_gain_range: assert property (speed_gain >= 16'h0014 && speed_gain <= 16'hc350)
        else $error("speed gain out of range");
    a_integ_comp_range: assert property (integral_comp >= 16'h0001 && integral_comp <= 16'hc350)
        else $error("integral compensation out of range");
    a_inertia_ratio_range: assert property (inertia_ratio <= 16'h0bb8)
        else $error("inertia ratio out of range");
    a_vib_freq_range: assert property (vibration_freq >= 16'h0001 && vibration_freq <= 16'h03e8)
        else $error("vibration frequency out of range");
endmodule : gain_switch_monitor

// ---- bench/motion_ctrl_model.sv ----
// motion controller model driving the switch inputs
`timescale 1ns/1ns
module motion_ctrl_model
    import gain_switch_pkg::*;
(
    input  wire logic              clk,
    input  wire logic              want_cmd,
    input  wire logic              vib_change,
    input  wire logic [DATA_W-1:0] freq_set,
    input  wire logic [DATA_W-1:0] droop_set,
    input  wire logic [DATA_W-1:0] speed_set,
    output logic                   gain_change_cmd,
    output logic      [DATA_W-1:0] command_freq,
    output logic      [DATA_W-1:0] droop_pulses,
    output logic      [DATA_W-1:0] motor_speed
);
    initial begin
        gain_change_cmd = 1'b0;
        command_freq = 16'h0000;
        droop_pulses = 16'h0000;
        motor_speed = 16'h0000;
    end
    always @(posedge clk) begin
        command_freq <= freq_set;
        droop_pulses <= droop_set;
        motor_speed <= speed_set;
        // vibration gain change waits for standstill
        if (!vib_change || motor_speed == 16'h0000) begin
            gain_change_cmd <= want_cmd;
        end
    end
endmodule : motion_ctrl_model

// ---- bench/test_gain_switch.sv ----
// self-checking bench for the gain-set switcher
`timescale 1ns/1ns
module test_gain_switch;
    import gain_switch_pkg::*;
    typedef struct {logic wr; logic [7:0] a; logic [15:0] d; logic [15:0] x; logic e;} row_t;
    logic              clk, reset_n, psel, penable, pwrite, pready, pslverr, active, err;
    logic              want_cmd, vib_change, gain_change_cmd;
    logic [7:0]        paddr;
    logic [31:0]       pwdata, prdata, rd;
    logic [DATA_W-1:0] freq_set, droop_set, speed_set, command_freq, droop_pulses, motor_speed;
    logic [DATA_W-1:0] g [6];
    logic [15:0]       alt_v [6] = '{16'h0064, 16'h0064, 16'h03e8, 16'h0200, 16'h0100, 16'h0200};
    int                miscompares, samples_checked;
    logic              c;
    row_t rows [16] = '{
        '{0, 8'h00, 0, 16'h0000, 0},
        '{0, 8'h04, 0, 16'h000a, 0},
        '{0, 8'h08, 0, 16'h0001, 0},
        '{0, 8'h0c, 0, 16'h0046, 0},
        '{0, 8'h10, 0, 16'h0025, 0},
        '{0, 8'h14, 0, 16'h0337, 0},
        '{0, 8'h18, 0, 16'h0151, 0},
        '{0, 8'h1c, 0, 16'h03e8, 0},
        '{1, 8'h04, 16'h2710, 16'h270f, 0},
        '{1, 8'h08, 16'h0065, 16'h0064, 0},
        '{1, 8'h10, 16'h0000, 16'h0001, 0},
        '{1, 8'h14, 16'hffff, 16'hc350, 0},
        '{1, 8'h18, 16'h0000, 16'h0001, 0},
        '{1, 8'h0c, 16'h0bb9, 16'h0bb8, 0},
        '{1, 8'h20, 16'h0000, 16'h0001, 0},
        '{0, 8'h80, 0, 16'h0000, 1}};
    logic [15:0]       modes [3] = '{16'h0010, 16'h0113, 16'h0023};
    logic [5:0]        masks [3] = '{6'h10, 6'h0d, 6'h2f};

    gain_switch dut (.clk, .reset_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
        .gain_change_cmd, .command_freq, .droop_pulses, .motor_speed, .inertia_ratio(g[0]),
        .position_gain(g[1]), .speed_gain(g[2]), .integral_comp(g[3]), .vibration_freq(g[4]),
        .resonance_freq(g[5]), .gain_switch_active(active));
    motion_ctrl_model ctrl (.clk, .want_cmd, .vib_change, .freq_set, .droop_set, .speed_set,
        .gain_change_cmd, .command_freq, .droop_pulses, .motor_speed);

    // ****************************************
    // helpers
    // ****************************************
    task automatic check(input string nm, input logic [31:0] x, input logic [31:0] s);
        samples_checked++;
        if (s !== x) begin
            miscompares++;
            $display("[FAIL] %s expected %h seen %h", nm, x, s);
        end
    endtask : check
    // entered just after a rising edge; holds the request until pready is seen
    task automatic apb(input logic w, input logic [7:0] a, input logic [15:0] d);
        int n;
        n = 0;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= {16'h0000, d};
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1 && n < 20) begin
            @(posedge clk);
            n++;
        end
        if (n == 20) begin
            miscompares++;
            $display("[FAIL] pready expected 1 seen %b", pready);
            final_report();
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask : apb
    task automatic chk_gains(input logic cond, input logic [5:0] en);
        // the registered outputs of the controller model add a cycle before the switch
        repeat (6) @(posedge clk);
        check("active", {31'h0, cond}, {31'h0, active});
        for (int i = 0; i < 6; i++) begin
            check("gain", (cond && en[i]) ? alt_v[i] : REG_RST[IDX_NORM_BASE + i], g[i]);
        end
    endtask : chk_gains
    task final_report;
        $display("comparisons %0d mismatches %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : final_report

    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    initial begin
        #(50 * 90000);
        miscompares++;
        $display("watchdog expired");
        final_report();
    end

    // ****************************************
    // main sequence
    // ****************************************
    initial begin
        {psel, penable, pwrite, paddr, pwdata, want_cmd, vib_change} = '0;
        {freq_set, droop_set, speed_set} = '0;
        reset_n = 1'b0;
        repeat (6) @(posedge clk);
        reset_n <= 1'b1;
        repeat (3) @(posedge clk);
        foreach (rows[i]) begin
            if (rows[i].wr) apb(1'b1, rows[i].a, rows[i].d);
            apb(1'b0, rows[i].a, 16'h0000);
            check("readback", {16'h0000, rows[i].x}, rd);
            check("slverr", {31'h0, rows[i].e}, {31'h0, err});
        end
        $display("register table done");
        for (int i = 0; i < 6; i++) apb(1'b1, 8'(8'h0c + 4 * i), alt_v[i]);
        apb(1'b1, 8'h04, 16'h0064);
        apb(1'b1, 8'h08, 16'h0000);
        apb(1'b1, 8'h3c, 16'h0013);
        // q: 0 below or instruction off, 1 at threshold or on, 2 above
        for (int s = 0; s < 5; s++) for (int p = 0; p < 2; p++) for (int q = 0; q < 3; q++) begin
            apb(1'b1, 8'h00, 16'(s | (p << 4)));
            apb(1'b1, 8'h44, 16'h0000);
            want_cmd <= (q == 1);
            // unselected quantities mirror the selected one about the threshold
            freq_set  <= (s == 2) ? 16'(16'h0063 + q) : 16'(16'h0065 - q);
            droop_set <= (s == 3) ? 16'(16'h0063 + q) : 16'(16'h0065 - q);
            speed_set <= (s == 4) ? 16'(16'h0063 + q) : 16'(16'h0065 - q);
            c = (s == 0) ? 1'b0 : (s == 1) ? ((q == 1) ^ p) : (p ? (q <= 1) : (q >= 1));
            chk_gains(c, 6'h1f);
        end
        $display("switch conditions done");
        apb(1'b1, 8'h00, 16'h0001);
        apb(1'b1, 8'h44, 16'h0000);
        want_cmd <= 1'b1;
        for (int m = 0; m < 3; m++) begin
            apb(1'b1, 8'h3c, modes[m]);
            chk_gains(1'b1, masks[m]);
        end
        $display("mode gating done");
        apb(1'b1, 8'h3c, 16'h0013);
        want_cmd <= 1'b0;
        speed_set <= 16'h0005;
        chk_gains(1'b0, 6'h1f);
        vib_change <= 1'b1;
        want_cmd <= 1'b1;
        chk_gains(1'b0, 6'h1f);
        speed_set <= 16'h0000;
        chk_gains(1'b1, 6'h1f);
        vib_change <= 1'b0;
        apb(1'b1, 8'h00, 16'h0000);
        chk_gains(1'b1, 6'h1f);
        apb(1'b0, 8'h40, 16'h0000);
        check("latched source", 32'h1, {28'h0, rd[6:3]});
        apb(1'b1, 8'h44, 16'h0000);
        chk_gains(1'b0, 6'h1f);
        $display("source latching done");
        apb(1'b1, 8'h08, 16'h0001);
        apb(1'b1, 8'h00, 16'h0001);
        want_cmd <= 1'b0;
        apb(1'b1, 8'h44, 16'h0000);
        repeat (10) @(posedge clk);
        want_cmd <= 1'b1;
        repeat (2600) @(posedge clk);
        check("lag first step", 1, {31'h0, g[1] > 16'h0025 && g[1] < 16'h0064});
        repeat (50000) @(posedge clk);
        check("lag settling", 1, {31'h0, g[1] >= 16'h005c && g[1] < 16'h0064});
        $display("gain lag done");
        reset_n <= 1'b0;
        repeat (2) @(posedge clk);
        reset_n <= 1'b1;
        repeat (3) @(posedge clk);
        apb(1'b0, 8'h00, 16'h0000);
        check("source after reset", 32'h0, rd);
        chk_gains(1'b0, 6'h00);
        $display("mid-run reset done");
        final_report();
    end
endmodule : test_gain_switch

bind gain_switch gain_switch_monitor mon (.clk, .reset_n, .psel, .penable, .prdata, .pready, .pslverr,
    .inertia_ratio, .position_gain, .speed_gain, .integral_comp, .vibration_freq);
